//--- hdl/disp_slave_cfg.svh
// Purpose: Constants for the two-wire display driver slave front end.
// Assumes: Included by the package user files by bare name.
// Notes: Pointer values and address prefix are fixed by the device.
`ifndef DISP_SLAVE_CFG_SVH
`define DISP_SLAVE_CFG_SVH
`define ADDR_PREFIX 3'h6
`define PTR_RESERVED 7'h0D
`define PTR_LAST 7'h7F
`define PTR_RESET 7'h00
`define STRAP_GND 2'h0
`define STRAP_VDD 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3
`endif

//--- hdl/disp_slave_pkg.sv
// Purpose: Types for the two-wire display driver slave front end.
// Assumes: Nothing beyond the constants header.
// Notes: The state record holds every flip-flop of the slave.
package disp_slave_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_READ, ST_ACK, ST_RACK,
        ST_IGNORE} phase_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic we;
    } reg_wr_t;
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] ad0_sync;
        logic [1:0] ad1_sync;
        logic [1:0] low_seen;
        logic [1:0] high_seen;
        logic scl_q;
        logic sda_q;
        phase_t phase;
        phase_t after_ack;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [6:0] ptr;
        logic reading;
        logic sda_low;
        logic first_data;
        reg_wr_t wr;
        logic busy;
    } state_t;
endpackage

//--- hdl/disp_slave.sv
// Purpose: Two-wire bus slave that loads a register pointer and writes registers.
// Assumes: CLK far faster than the bus clock; bus pins are pad signals.
// Notes: Read data comes from RD_DATA at the pointer in RD_ADDR.
module disp_slave
    import disp_slave_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [1:0] ADDRESS_STRAP_LOW,
    input wire logic [1:0] ADDRESS_STRAP_HIGH,
    output disp_slave_pkg::reg_wr_t REG_WR,
    output logic [6:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    output logic BUS_BUSY
);
    import disp_slave_pkg::*;
    `include "disp_slave_cfg.svh"

    state_t st;
    state_t next_st;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [1:0] low_code;
    logic [1:0] high_code;
    logic [6:0] own_addr;
    logic [6:0] ptr_inc;

    // Second stage of each synchroniser is the only copy logic reads.
    assign scl = st.scl_sync[1];
    assign sda = st.sda_sync[1];
    assign scl_rise = scl && !st.scl_q;
    assign scl_fall = !scl && st.scl_q;
    assign start_cond = scl && st.scl_q && st.sda_q && !sda;
    assign stop_cond = scl && st.scl_q && !st.sda_q && sda;

    // A strap tied to a bus line is told apart by following that line.
    function automatic logic [1:0] strap_code(input logic [1:0] pin);
        logic [1:0] code;
        code = `STRAP_GND;
        case (pin)
            2'h0: code = `STRAP_GND;
            2'h3: code = `STRAP_VDD;
            2'h1: code = `STRAP_SDA;
            2'h2: code = `STRAP_SCL;
            default: code = `STRAP_GND;
        endcase
        return code;
    endfunction

    // Pin levels kept as {seen with clock high, seen with data high}.
    // A single sample cannot tell a strap on a bus line from a fixed level,
    // so the decode only settles once both unequal bus states have been seen.
    always_comb begin
        low_code = strap_code(st.low_seen);
        high_code = strap_code(st.high_seen);
        own_addr = {`ADDR_PREFIX, high_code, low_code};
    end

    // Autoincrement skips no value but stops at the top one.
    always_comb begin
        if (st.ptr == `PTR_LAST) begin
            ptr_inc = st.ptr;
        end else begin
            ptr_inc = st.ptr + 7'h01;
        end
    end

    // One pass of the bit engine per CLK cycle.
    always_comb begin
        next_st = st;
        next_st.scl_sync = {st.scl_sync[0], SCL_IN};
        next_st.sda_sync = {st.sda_sync[0], SDA_IN};
        next_st.ad0_sync = {st.ad0_sync[0], ADDRESS_STRAP_LOW[0] ^ ADDRESS_STRAP_LOW[1]};
        next_st.ad1_sync = {st.ad1_sync[0], ADDRESS_STRAP_HIGH[0] ^ ADDRESS_STRAP_HIGH[1]};
        next_st.scl_q = scl;
        next_st.sda_q = sda;
        next_st.wr.we = 1'b0;
        // Every frame shows both unequal line states before its address ends.
        if (scl && !sda) begin
            next_st.low_seen[1] = st.ad0_sync[1];
            next_st.high_seen[1] = st.ad1_sync[1];
        end
        if (!scl && sda) begin
            next_st.low_seen[0] = st.ad0_sync[1];
            next_st.high_seen[0] = st.ad1_sync[1];
        end
        if (start_cond) begin
            next_st.phase = ST_ADDR;
            next_st.bit_cnt = 4'h0;
            next_st.sda_low = 1'b0;
            next_st.busy = 1'b1;
        end else if (stop_cond) begin
            next_st.phase = ST_IDLE;
            next_st.sda_low = 1'b0;
            next_st.busy = 1'b0;
        end else begin
            case (st.phase)
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (scl_rise) begin
                        next_st.shift = {st.shift[6:0], sda};
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                    end
                    if (scl_fall && st.bit_cnt == 4'h8) begin
                        next_st.bit_cnt = 4'h0;
                        if (st.phase == ST_ADDR && st.shift[7:1] != own_addr) begin
                            next_st.phase = ST_IGNORE;
                        end else begin
                            next_st.sda_low = 1'b1;
                            next_st.phase = ST_ACK;
                            if (st.phase == ST_ADDR) begin
                                next_st.reading = st.shift[0];
                                next_st.after_ack = st.shift[0] ? ST_READ : ST_CMD;
                                next_st.first_data = 1'b1;
                            end else if (st.phase == ST_CMD) begin
                                next_st.ptr = st.shift[6:0];
                                next_st.after_ack = ST_DATA;
                            end else begin
                                next_st.wr.addr = {1'b0, st.ptr};
                                next_st.wr.data = st.shift;
                                next_st.wr.we = st.ptr != `PTR_RESERVED;
                                next_st.ptr = ptr_inc;
                                next_st.after_ack = ST_DATA;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_st.phase = st.after_ack;
                        next_st.sda_low = 1'b0;
                        if (st.after_ack == ST_READ) begin
                            next_st.shift = RD_DATA;
                            next_st.sda_low = !RD_DATA[7];
                            next_st.bit_cnt = 4'h1;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (st.bit_cnt == 4'h8) begin
                            next_st.sda_low = 1'b0;
                            next_st.phase = ST_RACK;
                            next_st.ptr = ptr_inc;
                        end else begin
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.sda_low = !st.shift[6];
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                        end
                    end
                end
                // The master's answer is read as its clock falls, before its data hold ends.
                ST_RACK: begin
                    if (scl_fall) begin
                        if (sda) begin
                            next_st.phase = ST_IGNORE;
                        end else begin
                            next_st.phase = ST_READ;
                            next_st.shift = RD_DATA;
                            next_st.sda_low = !RD_DATA[7];
                            next_st.bit_cnt = 4'h1;
                        end
                    end
                end
                default: begin
                    next_st.sda_low = 1'b0;
                end
            endcase
        end
    end

    // Synchronous active-low reset returns to a released, idle bus.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st <= '{scl_sync: 2'h3, sda_sync: 2'h3, ad0_sync: 2'h0, ad1_sync: 2'h0,
                low_seen: 2'h0, high_seen: 2'h0,
                scl_q: 1'b1, sda_q: 1'b1, phase: ST_IDLE, after_ack: ST_IDLE,
                bit_cnt: 4'h0, shift: 8'h00, ptr: `PTR_RESET, reading: 1'b0,
                sda_low: 1'b0, first_data: 1'b0, wr: '0, busy: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Open drain: only ever pulls low; the clock pin has no driver at all.
    assign SDA_OUT = 1'b0;
    assign SDA_OE = st.sda_low;
    assign REG_WR = st.wr;
    assign RD_ADDR = st.ptr;
    assign BUS_BUSY = st.busy;

    ack_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
        st.phase == ST_ACK && !scl_fall |=> SDA_OE)
        else $error("Acknowledge released early.");
    stop_release_a: assert property (@(posedge CLK) disable iff (!NRST)
        stop_cond |=> !SDA_OE && !BUS_BUSY)
        else $error("Line not released after stop.");
    start_addr_a: assert property (@(posedge CLK) disable iff (!NRST)
        start_cond |=> st.phase == ST_ADDR && st.ptr == $past(st.ptr))
        else $error("Start did not restart address.");
    reserved_a: assert property (@(posedge CLK) disable iff (!NRST)
        REG_WR.we |-> REG_WR.addr[6:0] != `PTR_RESERVED)
        else $error("Reserved register written.");
    top_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
        REG_WR.we && REG_WR.addr[6:0] == `PTR_LAST |-> st.ptr == `PTR_LAST)
        else $error("Pointer left top value.");
    ignore_a: assert property (@(posedge CLK) disable iff (!NRST)
        st.phase == ST_IGNORE |-> !SDA_OE)
        else $error("Driving while ignoring.");
    write_inc_a: assert property (@(posedge CLK) disable iff (!NRST)
        REG_WR.we && REG_WR.addr[6:0] != `PTR_LAST |-> st.ptr == REG_WR.addr[6:0] + 7'h01)
        else $error("Pointer did not advance.");
    stable_high_a: assert property (@(posedge CLK) disable iff (!NRST)
        scl && st.scl_q && !start_cond && st.phase == ST_READ |=> $stable(SDA_OE) || !scl)
        else $error("Data changed while clock high.");
endmodule

//--- verif/bus_master_model.sv
// Purpose: Behavioural two-wire bus master that clocks the slave.
// Assumes: Tasks are called from the bench; the data wire has a pull-up.
// Notes: Each half bit is four clk cycles, so one bit lasts 32 ns.
module bus_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both lines rest released while no frame is running.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Data moves only while the clock is low, so the slave never sees a false condition.
    task automatic bit_cyc(input logic drv_low, output logic seen);
        sda_low <= drv_low;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        seen = sda;
        scl <= 1'b0;
        @(posedge clk);
    endtask
    // A repeated start first lets both lines rise again.
    task automatic start();
        if (!scl) begin
            sda_low <= 1'b0;
            repeat (3) @(posedge clk);
            scl <= 1'b1;
            repeat (4) @(posedge clk);
        end
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
        @(posedge clk);
    endtask
    // Data rises while the clock is high to free the bus.
    task automatic stop();
        sda_low <= 1'b1;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Eight bits with the most significant first, then the ninth acknowledge slot.
    task automatic xfer(input logic [7:0] tx, input logic ack_low, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_cyc(~tx[i], rx[i]);
        bit_cyc(ack_low, ack);
    endtask
endmodule

//--- verif/display_driver_i2c_slave_front_end_test.sv
// Purpose: Self-checking bench for the two-wire display slave.
// Assumes: Read data is a fixed pattern of the pointer.
// Notes: Straps use ground, supply and, in t_strap, the bus lines; decode settles only with bus activity.
module display_driver_i2c_slave_front_end_test;
    timeunit 1ns;
    timeprecision 1ps;
    import disp_slave_pkg::*;
    localparam logic [6:0] SELF = 7'h61;
    logic clk, nrst, scl, sda_low, sda_oe, sda_out, busy;
    logic [1:0] strap_lo, strap_hi;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    reg_wr_t reg_wr;
    logic [15:0] writes[$];
    int failures, n_compared;
    // Open-drain data wire with a pull-up.
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    assign rd_data = {1'b1, rd_addr} ^ 8'h5A;
    // Strap codes: 0 ground, 1 supply, 2 follows the data wire, 3 follows the clock.
    wire [1:0] pin_lo = {strap_lo[1] & (strap_lo[0] ? scl : sda), ~strap_lo[1] & strap_lo[0]};
    wire [1:0] pin_hi = {strap_hi[1] & (strap_hi[0] ? scl : sda), ~strap_hi[1] & strap_hi[0]};
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    disp_slave i_dut (.CLK(clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDRESS_STRAP_LOW(pin_lo), .ADDRESS_STRAP_HIGH(pin_hi),
        .REG_WR(reg_wr), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .BUS_BUSY(busy));
    bus_master_model i_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // Every write pulse is logged so that missing or extra writes both show.
    always @(posedge clk) if (reg_wr.we === 1'b1) writes.push_back({reg_wr.addr, reg_wr.data});
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic a;
        i_master.xfer(b, 1'b0, rx, a);
        chk("ack", {15'h0, exp_ack}, {15'h0, a});
    endtask
    task automatic addr_cmd(input logic [7:0] cmd);
        i_master.start();
        put({SELF, 1'b0}, 1'b0);
        put(cmd, 1'b0);
        chk("busy", 16'h0001, {15'h0, busy});
        chk("pointer", {9'h0, cmd[6:0]}, {9'h0, rd_addr});
    endtask
    task automatic t_autoinc();
        writes.delete();
        addr_cmd(8'h0C);
        put(8'hA1, 1'b0);
        put(8'hB2, 1'b0);
        put(8'hC3, 1'b0);
        i_master.stop();
        chk("first write", 16'h0CA1, writes[0]);
        chk("third write", 16'h0EC3, writes[1]);
        chk("write count", 16'h0002, 16'(writes.size()));
        chk("busy", 16'h0000, {15'h0, busy});
        $display("t_autoinc done");
    endtask
    task automatic t_hold();
        writes.delete();
        addr_cmd(8'h7E);
        i_master.stop();
        chk("write count", 16'h0000, 16'(writes.size()));
        addr_cmd(8'h7E);
        put(8'h11, 1'b0);
        put(8'h22, 1'b0);
        put(8'h33, 1'b0);
        i_master.stop();
        chk("write one", 16'h7E11, writes[0]);
        chk("write two", 16'h7F22, writes[1]);
        chk("write three", 16'h7F33, writes[2]);
        $display("t_hold done");
    endtask
    task automatic t_read();
        logic [7:0] rx;
        logic a;
        addr_cmd(8'h20);
        i_master.start();
        put({SELF, 1'b1}, 1'b0);
        i_master.xfer(8'hFF, 1'b1, rx, a);
        chk("read one", {8'h0, 8'hA0 ^ 8'h5A}, {8'h0, rx});
        i_master.xfer(8'hFF, 1'b0, rx, a);
        chk("read two", {8'h0, 8'hA1 ^ 8'h5A}, {8'h0, rx});
        i_master.stop();
        chk("pointer", 16'h0022, {9'h0, rd_addr});
        $display("t_read done");
    endtask
    task automatic t_strap();
        writes.delete();
        strap_hi <= 2'b01;
        strap_lo <= 2'b00;
        repeat (8) @(posedge clk);
        i_master.start();
        put({SELF, 1'b0}, 1'b1);
        put(8'h05, 1'b1);
        i_master.stop();
        chk("write count", 16'h0000, 16'(writes.size()));
        chk("pointer", 16'h0022, {9'h0, rd_addr});
        i_master.start();
        put({7'h64, 1'b0}, 1'b0);
        put(8'h30, 1'b0);
        i_master.stop();
        chk("pointer", 16'h0030, {9'h0, rd_addr});
        // High pin follows the data wire, low pin follows the clock.
        strap_hi <= 2'b10;
        strap_lo <= 2'b11;
        repeat (8) @(posedge clk);
        i_master.start();
        put({7'h6B, 1'b0}, 1'b0);
        put(8'h31, 1'b0);
        i_master.stop();
        chk("pointer", 16'h0031, {9'h0, rd_addr});
        $display("t_strap done");
    endtask
    task automatic summarize();
        $display("Counts: compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // The four tests need roughly eighteen hundred cycles; the margin is generous.
    initial begin
        #80000;
        failures++;
        summarize();
    end
    initial begin
        nrst = 1'b0;
        strap_lo = 2'b01;
        strap_hi = 2'b00;
        failures = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk("idle data", 16'h0001, {15'h0, sda});
        t_autoinc();
        t_hold();
        t_read();
        t_strap();
        summarize();
    end
endmodule
